// ==== common/eio_pkg.sv ====
// shared constants and carrier types for the eight-bit io port
package eio_pkg;

  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 16;
  localparam int DATA_WIDTH = 32;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_OUTPUT_LATCH = 14'h0009;
  localparam logic [13:0] IDX_OPEN_DRAIN = 14'h1F87;
  localparam logic [13:0] IDX_DIRECTION = 14'h1F8F;
  localparam logic [13:0] IDX_PIN_LEVEL = 14'h1F90;

  localparam logic [15:0] ADR_OUTPUT_LATCH = {IDX_OUTPUT_LATCH, 2'b00};
  localparam logic [15:0] ADR_OPEN_DRAIN = {IDX_OPEN_DRAIN, 2'b00};
  localparam logic [15:0] ADR_DIRECTION = {IDX_DIRECTION, 2'b00};
  localparam logic [15:0] ADR_PIN_LEVEL = {IDX_PIN_LEVEL, 2'b00};

  localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
  localparam logic [7:0] SYNC_RST = 8'h00;

  // direction and drive style encodings per bit
  localparam logic DIR_INPUT = 1'b0;
  localparam logic DIR_OUTPUT = 1'b1;
  localparam logic STYLE_TRISTATE = 1'b0;
  localparam logic STYLE_OPEN_DRAIN = 1'b1;

  // register selected by a bus address
  typedef enum logic [4:0] {
    SEL_NONE = 5'b00001,
    SEL_OUTPUT_LATCH = 5'b00010,
    SEL_OPEN_DRAIN = 5'b00100,
    SEL_DIRECTION = 5'b01000,
    SEL_PIN_LEVEL = 5'b10000
  } eio_sel_type;

  // per-pin drive toward the pad; oe_n low while driving
  typedef struct packed {
    logic [PORT_WIDTH-1:0] value;
    logic [PORT_WIDTH-1:0] oe_n;
  } eio_pad_out_type;

  // port configuration carried from registers to the pin logic
  typedef struct packed {
    logic [PORT_WIDTH-1:0] latch;
    logic [PORT_WIDTH-1:0] open_drain;
    logic [PORT_WIDTH-1:0] direction;
  } eio_cfg_type;

endpackage : eio_pkg

// ==== hw/eio_pin_mux.sv ====
// per-pin drive selection and read-back selection
`timescale 1ns/1ps
module eio_pin_mux (
  input wire eio_pkg::eio_cfg_type cfg_i, // latch, style, direction
  input wire logic osc_fail_rst_i, // oscillation failure reset
  input wire logic rmw_i, // read phase of read-modify-write
  input wire logic [eio_pkg::PORT_WIDTH-1:0] level_i, // synced pin levels
  output eio_pkg::eio_pad_out_type pad_o, // pad value and enable
  output logic [eio_pkg::PORT_WIDTH-1:0] read_o, // cpu read value
  output logic [eio_pkg::PORT_WIDTH-1:0] ctrl_o // peripheral control input
);
  import eio_pkg::*;

  genvar gi;
  generate
    for (gi = 0; gi < PORT_WIDTH; gi++)
    begin : g_pin
      logic push_drive;
      logic od_pull;
      logic latch_view;
      assign push_drive = (cfg_i.open_drain[gi] == STYLE_TRISTATE) &&
                          (cfg_i.direction[gi] == DIR_OUTPUT); // see [R1] [R8]
      // open drain only ever pulls low; a 1 leaves the pin floating
      assign od_pull = (cfg_i.open_drain[gi] == STYLE_OPEN_DRAIN) &&
                       !cfg_i.latch[gi]; // see [R4] [R9]
      // pads released at once, no clock needed, if the oscillator died
      assign pad_o.oe_n[gi] = osc_fail_rst_i ||
                              !(push_drive || od_pull); // see [R6] [R7] [R11]
      // a released pad shows 0 so no stale latch leaks past the enable
      assign pad_o.value[gi] = (push_drive && !osc_fail_rst_i) ?
                               cfg_i.latch[gi] : 1'b0; // see [R6]
      assign latch_view = push_drive ||
                          (rmw_i && cfg_i.open_drain[gi]); // see [R10]
      assign read_o[gi] = latch_view ? cfg_i.latch[gi] : level_i[gi];
      assign ctrl_o[gi] = push_drive ? cfg_i.latch[gi]
                                     : level_i[gi]; // see [R7] [R8] [R9]
    end
  endgenerate

endmodule : eio_pin_mux

// ==== hw/eio_port.sv ====
// eight-bit io port with open-drain select behind a wishbone slave
`timescale 1ns/1ps
// Operation
// [R1] Eight pins, each with a direction bit where 0 is input and 1 output.
// [R2] Reset clears the direction register so every pin starts as input.
// [R3] Reset clears all eight bits of the output latch.
// [R4] Each pin's open-drain bit selects push-pull at 0 and open drain at 1.
// [R5] Reset clears the open-drain register so every pin is push-pull.
// [R6] The oscillation failure reset releases all eight pins to high-Z.
// [R7] Push-pull input pins float and reads and control see the pin level.
// [R8] Push-pull output pins drive the latch and reads see the latch.
// [R9] Open-drain pins pull low on latch 0, float on 1, reads see the pin.
// [R10] An open-drain pin returns its latch in a read-modify-write read.
// [R11] Each pin is separate input, output value and output enable signals.
module eio_port (
  input wire logic clk_i, // system clock, 50 MHz
  input wire logic rst_i, // synchronous reset, high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic lock_i, // marks the read of a read-modify-write
  input wire logic [eio_pkg::ADDR_WIDTH-1:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [eio_pkg::DATA_WIDTH-1:0] dat_i, // wishbone write data
  output logic [eio_pkg::DATA_WIDTH-1:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic osc_fail_rst_i, // oscillation failure reset, high
  input wire logic [eio_pkg::PORT_WIDTH-1:0] pin_i, // pad input levels
  output logic [eio_pkg::PORT_WIDTH-1:0] pin_o, // pad output values
  output logic [eio_pkg::PORT_WIDTH-1:0] pin_oe_n_o, // pad enable, low drives
  output logic [eio_pkg::PORT_WIDTH-1:0] ctrl_in_o // peripheral control input
);
  import eio_pkg::*;

  typedef struct packed {
    eio_cfg_type cfg;
    logic ack;
    logic [DATA_WIDTH-1:0] rdata;
  } eio_state_type;

  eio_state_type state;
  eio_state_type next_state;

  logic [PORT_WIDTH-1:0] level;
  logic [PORT_WIDTH-1:0] read_view;
  logic [PORT_WIDTH-1:0] raw_read_view;
  eio_pad_out_type pad;
  eio_sel_type sel;
  logic req;

  // address decode shared by the read and write paths
  function automatic eio_sel_type decode_sel(
    input logic [ADDR_WIDTH-1:0] adr
  );
    eio_sel_type s;
    s = SEL_NONE;
    case (adr)
      ADR_OUTPUT_LATCH: s = SEL_OUTPUT_LATCH;
      ADR_OPEN_DRAIN: s = SEL_OPEN_DRAIN;
      ADR_DIRECTION: s = SEL_DIRECTION;
      ADR_PIN_LEVEL: s = SEL_PIN_LEVEL;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction : decode_sel

  eio_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pin_i),
    .sync_o(level)
  );

  eio_pin_mux u_mux (
    .cfg_i(state.cfg),
    .osc_fail_rst_i(osc_fail_rst_i),
    .rmw_i(lock_i),
    .level_i(level),
    .pad_o(pad),
    .read_o(read_view),
    .ctrl_o(ctrl_in_o)
  );

  // plain pin readback ignores the lock marker
  eio_pin_mux u_raw (
    .cfg_i(state.cfg),
    .osc_fail_rst_i(osc_fail_rst_i),
    .rmw_i(1'b0),
    .level_i(level),
    .pad_o(),
    .read_o(raw_read_view),
    .ctrl_o()
  );

  assign sel = decode_sel(adr_i);
  // one ack per request; ack drops the cycle after it is given
  assign req = cyc_i && stb_i && !state.ack;

  always_comb
  begin
    next_state = state;
    next_state.ack = req;
    next_state.rdata = RDATA_NONE;
    if (req && !we_i)
    begin
      case (sel)
        SEL_OUTPUT_LATCH: next_state.rdata[7:0] = read_view; // see [R10]
        SEL_OPEN_DRAIN: next_state.rdata[7:0] = state.cfg.open_drain;
        SEL_DIRECTION: next_state.rdata[7:0] = state.cfg.direction;
        SEL_PIN_LEVEL: next_state.rdata[7:0] = raw_read_view;
        SEL_NONE: next_state.rdata = RDATA_NONE;
        default: next_state.rdata = RDATA_NONE;
      endcase
    end
    // writes land on the ack edge; only lane 0 carries data
    if (req && we_i && sel_i[0])
    begin
      case (sel)
        SEL_OUTPUT_LATCH: next_state.cfg.latch = dat_i[7:0];
        SEL_OPEN_DRAIN: next_state.cfg.open_drain = dat_i[7:0]; // see [R4]
        SEL_DIRECTION: next_state.cfg.direction = dat_i[7:0]; // see [R1]
        SEL_PIN_LEVEL: next_state.cfg = state.cfg;
        SEL_NONE: next_state.cfg = state.cfg;
        default: next_state.cfg = state.cfg;
      endcase
    end
    if (rst_i)
    begin
      next_state.cfg.direction = RST_DIRECTION; // see [R2]
      next_state.cfg.latch = RST_OUTPUT_LATCH; // see [R3]
      next_state.cfg.open_drain = RST_OPEN_DRAIN; // see [R5]
      next_state.ack = 1'b0;
      next_state.rdata = RDATA_NONE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    state <= next_state;
  end

  assign dat_o = state.rdata;
  assign ack_o = state.ack;
  assign pin_o = pad.value; // see [R11]
  assign pin_oe_n_o = pad.oe_n;

endmodule : eio_port

// ==== hw/eio_sync.sv ====
// two-stage synchroniser for the eight pad inputs
`timescale 1ns/1ps
module eio_sync (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [eio_pkg::PORT_WIDTH-1:0] async_i, // raw pad levels
  output logic [eio_pkg::PORT_WIDTH-1:0] sync_o // synchronised levels
);
  import eio_pkg::*;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] meta;
    logic [PORT_WIDTH-1:0] stable;
  } eio_sync_state_type;

  eio_sync_state_type state;
  eio_sync_state_type next_state;

  // first stage feeds only the second stage
  always_comb
  begin
    next_state.meta = async_i;
    next_state.stable = state.meta;
    if (rst_i)
    begin
      next_state.meta = SYNC_RST;
      next_state.stable = SYNC_RST;
    end
  end

  always_ff @(posedge clk_i)
  begin
    state <= next_state;
  end

  assign sync_o = state.stable;

endmodule : eio_sync

// ==== sim/eio_board.sv ====
// board model holding the eight pads where the port lets go
`timescale 1ns/1ps
module eio_board (
  input wire logic [7:0] pin_o, // port value
  input wire logic [7:0] pin_oe_n_o, // port enable, low drives
  input wire logic [7:0] ext_i, // level the board holds
  output logic [7:0] pin_i // resolved pad level
);
  // board resistors lose to the port wherever it drives
  assign pin_i = (pin_o & ~pin_oe_n_o) | (ext_i & pin_oe_n_o);
endmodule : eio_board

// ==== sim/eio_port_chk.sv ====
// concurrent checks on the io port top ports
`timescale 1ns/1ps
module eio_port_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic cyc_i, // cycle
  input wire logic stb_i, // strobe
  input wire logic we_i, // write
  input wire logic ack_o, // ack
  input wire logic osc_fail_rst_i, // osc fail
  input wire logic [7:0] pin_i, // pad level
  input wire logic [7:0] pin_o, // pad value
  input wire logic [7:0] pin_oe_n_o, // pad enable
  input wire logic [7:0] ctrl_in_o // control view
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_idle: assert property ($fell(rst_i) |->
    pin_oe_n_o == 8'hFF && pin_o == 8'h00) else $error("not idle");
  a_osc_release: assert property (osc_fail_rst_i |->
    pin_oe_n_o == 8'hFF) else $error("pin driven in osc fail");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  a_float_low: assert property ((pin_o & pin_oe_n_o) == 8'h00)
    else $error("value on floating pin");
  a_ctrl_drive: assert property ((ctrl_in_o & pin_o) == pin_o)
    else $error("control misses latch");
  a_oe_hold: assert property (!(cyc_i && stb_i && we_i) ##1
    $stable(osc_fail_rst_i) |-> $stable(pin_oe_n_o))
    else $error("enable moved alone");
  a_sync_delay: assert property (pin_oe_n_o == 8'hFF &&
    !osc_fail_rst_i && !$past(rst_i) && !$past(rst_i, 2)
    |-> ctrl_in_o == $past(pin_i, 2)) else $error("control not pin");
  // main scenarios reached
  c_osc: cover property (osc_fail_rst_i);
  c_write: cover property (ack_o && we_i);
  c_drive_all: cover property (pin_oe_n_o == 8'h00);
endmodule : eio_port_chk

// ==== sim/tb.sv ====
// self-checking bench for the io port
`timescale 1ns/1ps
module tb;
  import eio_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
  logic we_i = 1'h0, lock_i = 1'h0, osc_fail_rst_i = 1'h0, ack_o;
  logic [15:0] adr_i = 16'h0;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [7:0] pin_i, pin_o, pin_oe_n_o, ctrl_in_o, ext = 8'hFF;
  int bad_count = 0, comparisons = 0;
  // od, dir, latch, board, oe_n, value, plain read, rmw read
  logic [63:0] rows [5] = '{64'hF0CC_AA55_A308_09A9,
    64'hF0CC_AAAA_A308_AAAA, 64'h0000_FF3C_FF00_3C3C,
    64'h00FF_5AC3_005A_5A5A, 64'hFF00_0FFF_0F00_0F0F};
  always #10 clk_i = ~clk_i;
  eio_port dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .lock_i(lock_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .osc_fail_rst_i(osc_fail_rst_i),
    .pin_i(pin_i),
    .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o),
    .ctrl_in_o(ctrl_in_o)
  );
  eio_board u_board (.pin_o, .pin_oe_n_o, .ext_i(ext), .pin_i);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // reads compare against d; master waits for ack, never a fixed count
  task automatic wb(input logic w, input logic [15:0] a,
    input logic [7:0] d, input logic lk);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    lock_i <= lk;
    repeat (16)
      if (ack_o !== 1'h1)
        @(posedge clk_i);
    if (ack_o !== 1'h1)
    begin
      bad_count++;
      final_report();
    end
    if (!w)
      chk(dat_o, {24'h0, d});
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    lock_i <= 1'h0;
    @(posedge clk_i);
  endtask : wb
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    chk(pin_oe_n_o, 8'hFF);
    wb(1'h0, ADR_DIRECTION, 8'h00, 1'h0);
    wb(1'h0, ADR_OPEN_DRAIN, 8'h00, 1'h0);
    wb(1'h1, ADR_OPEN_DRAIN, 8'hFF, 1'h0);
    wb(1'h0, ADR_OUTPUT_LATCH, 8'h00, 1'h1);
    foreach (rows[i])
    begin
      ext <= rows[i][39:32];
      wb(1'h1, ADR_OPEN_DRAIN, rows[i][63:56], 1'h0);
      wb(1'h1, ADR_DIRECTION, rows[i][55:48], 1'h0);
      wb(1'h1, ADR_OUTPUT_LATCH, rows[i][47:40], 1'h0);
      repeat (3) @(posedge clk_i);
      chk(pin_oe_n_o, rows[i][31:24]);
      chk(pin_o, rows[i][23:16]);
      chk(ctrl_in_o, rows[i][15:8]);
      wb(1'h0, ADR_OUTPUT_LATCH, rows[i][15:8], 1'h0);
      wb(1'h0, ADR_OUTPUT_LATCH, rows[i][7:0], 1'h1);
      wb(1'h0, ADR_PIN_LEVEL, rows[i][15:8], 1'h1);
    end
    osc_fail_rst_i <= 1'h1;
    @(posedge clk_i);
    chk(pin_oe_n_o, 8'hFF);
    osc_fail_rst_i <= 1'h0;
    wb(1'h0, ADR_OUTPUT_LATCH, 8'h0F, 1'h1);
    // unmapped, byte-disabled and pin-level writes leave the latch alone
    wb(1'h1, 16'h0100, 8'hFF, 1'h0);
    wb(1'h0, 16'h0100, 8'h00, 1'h0);
    sel_i <= 4'hE;
    wb(1'h1, ADR_OUTPUT_LATCH, 8'hF0, 1'h0);
    sel_i <= 4'hF;
    wb(1'h0, ADR_OUTPUT_LATCH, 8'h0F, 1'h1);
    wb(1'h1, ADR_PIN_LEVEL, 8'hAA, 1'h0);
    wb(1'h0, ADR_OUTPUT_LATCH, 8'h0F, 1'h1);
    // push-pull drive, which the oscillator fault must let go of
    wb(1'h1, ADR_OPEN_DRAIN, 8'h00, 1'h0);
    wb(1'h1, ADR_DIRECTION, 8'hFF, 1'h0);
    chk(pin_oe_n_o, 8'h00);
    chk(pin_o, 8'h0F);
    osc_fail_rst_i <= 1'h1;
    @(posedge clk_i);
    chk(pin_oe_n_o, 8'hFF);
    osc_fail_rst_i <= 1'h0;
    @(posedge clk_i);
    chk(pin_oe_n_o, 8'h00);
    // mid-run reset must undo the drive set up above
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    chk(pin_oe_n_o, 8'hFF);
    chk(pin_o, 8'h00);
    wb(1'h0, ADR_DIRECTION, 8'h00, 1'h0);
    wb(1'h0, ADR_OPEN_DRAIN, 8'h00, 1'h0);
    wb(1'h1, ADR_OPEN_DRAIN, 8'hFF, 1'h0);
    wb(1'h0, ADR_OUTPUT_LATCH, 8'h00, 1'h1);
    final_report();
  end
endmodule : tb
bind eio_port eio_port_chk u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .ack_o(ack_o),
  .osc_fail_rst_i(osc_fail_rst_i),
  .pin_i(pin_i),
  .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o),
  .ctrl_in_o(ctrl_in_o)
);
